// file: rtl/timer_event_counter_p.sv
`timescale 1ns/1ps
`default_nettype none
module timer_event_counter_p
	import tmr_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire ctl_t ctl,
	input wire cmp_wr_t cmp_wr,
	input wire logic capture_trigger_pin_0,
	input wire logic capture_trigger_pin_1,
	input wire logic ext_trigger_pin,
	output logic timer_out_pin_0,
	output logic timer_out_pin_1,
	output logic [CNT_W-1:0] counter_value_reg,
	output logic [CNT_W-1:0] compare_reg_0,
	output logic [CNT_W-1:0] compare_reg_1,
	output logic compare0_match_interrupt,
	output logic compare1_match_interrupt
);
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_RUN = 2'b10
	} st_t;

	st_t st_q;
	logic [DIV_W-1:0] div_q;
	logic [DIV_W-1:0] div_mask;
	logic [2:0] pin_prev_q;
	logic ff0_q;
	logic ff1_q;
	logic ext_clk;
	logic trig_mode;
	logic cap_mode;
	logic tick;
	logic trig_go;
	logic cap0_hit;
	logic cap1_hit;
	logic run;
	logic at_top;
	logic m0;
	logic m1;
	logic osp_ok;

	function automatic logic edge_hit(input logic [1:0] sel, input logic now, input logic prev);
		case (sel)
			EDGE_RISE: edge_hit = now & ~prev;
			EDGE_FALL: edge_hit = ~now & prev;
			EDGE_BOTH: edge_hit = now ^ prev;
			default: edge_hit = 1'b0;
		endcase
	endfunction

	assign ext_clk = ctl.external_event_clock_select | (ctl.mode == MODE_EXT_EVENT);
	assign trig_mode = (ctl.mode == MODE_EXT_TRIG) | (ctl.mode == MODE_ONE_SHOT);
	assign cap_mode = (ctl.mode == MODE_FREE_RUN) | (ctl.mode == MODE_PULSE_WIDTH);
	assign div_mask = DIV_W'((9'h001 << ctl.prescale) - 9'h001);

	// External count clock enters on capture pin 0 only
	assign tick = ext_clk ?
		edge_hit(ctl.event_edge_select, capture_trigger_pin_0, pin_prev_q[0]) :
		((div_q & div_mask) == div_mask);

	assign trig_go = trig_mode & (ctl.software_trigger |
		edge_hit(ctl.trigger_edge_select, ext_trigger_pin, pin_prev_q[2]));

	assign cap0_hit = cap_mode &
		edge_hit(ctl.capture_edge_select[CAP0_LSB +: 2], capture_trigger_pin_0, pin_prev_q[0]);
	assign cap1_hit = cap_mode &
		edge_hit(ctl.capture_edge_select[CAP1_LSB +: 2], capture_trigger_pin_1, pin_prev_q[1]);

	assign run = ctl.count_run_enable & (st_q == ST_RUN);
	assign at_top = ~cap_mode & (counter_value_reg == compare_reg_0);
	// Compare matches are off on a channel whose capture_compare_select_0 or capture_compare_select_1 bit is set in a capture mode
	assign m0 = run & tick & (counter_value_reg == compare_reg_0) &
		~(cap_mode & ctl.capture_compare_select_0);
	assign m1 = run & tick & (counter_value_reg == compare_reg_1) &
		~(cap_mode & ctl.capture_compare_select_1);
	assign osp_ok = (ctl.mode != MODE_ONE_SHOT) | (compare_reg_1 <= compare_reg_0);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pin_prev_q <= 3'h0;
		end else begin
			pin_prev_q <= {ext_trigger_pin, capture_trigger_pin_1, capture_trigger_pin_0};
		end
	end

	// Prescaler restarts when count_run_enable is set, not on a trigger, so the first tick after enable is a full period
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			div_q <= DIV_RST;
		end else if (!ctl.count_run_enable) begin
			div_q <= DIV_RST;
		end else begin
			div_q <= div_q + 8'h01;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= ST_IDLE;
		end else if (!ctl.count_run_enable) begin
			st_q <= ST_IDLE;
		end else begin
			case (st_q)
				ST_IDLE: begin
					if (!trig_mode || trig_go) begin
						st_q <= ST_RUN;
					end
				end
				ST_RUN: begin
					if (ctl.mode == MODE_ONE_SHOT && m0 && !trig_go) begin
						st_q <= ST_IDLE;
					end
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			counter_value_reg <= CNT_RST;
		end else if (!ctl.count_run_enable) begin
			counter_value_reg <= CNT_RST;
		end else if (trig_go) begin
			counter_value_reg <= CNT_RST;
		end else if (ctl.mode == MODE_PULSE_WIDTH && cap0_hit) begin
			counter_value_reg <= CNT_RST;
		end else if (run && tick) begin
			if (at_top) begin
				counter_value_reg <= CNT_RST;
			end else begin
				counter_value_reg <= counter_value_reg + 16'h0001;
			end
		end
	end

	// Capture takes priority over a software write in the same cycle
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			compare_reg_0 <= CMP_RST;
		end else if (cap0_hit && (ctl.capture_compare_select_0 || ctl.mode == MODE_PULSE_WIDTH)) begin
			compare_reg_0 <= counter_value_reg;
		end else if (cmp_wr.wr0) begin
			compare_reg_0 <= cmp_wr.data;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			compare_reg_1 <= CMP_RST;
		end else if (cap1_hit && (ctl.capture_compare_select_1 || ctl.mode == MODE_PULSE_WIDTH)) begin
			compare_reg_1 <= counter_value_reg;
		end else if (cmp_wr.wr1) begin
			compare_reg_1 <= cmp_wr.data;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			compare0_match_interrupt <= 1'b0;
			compare1_match_interrupt <= 1'b0;
		end else begin
			compare0_match_interrupt <= m0;
			compare1_match_interrupt <= m1;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ff0_q <= 1'b0;
			ff1_q <= 1'b0;
		end else if (!ctl.count_run_enable || ctl.mode == MODE_EXT_EVENT
			|| ctl.mode == MODE_PULSE_WIDTH || !osp_ok) begin
			ff0_q <= 1'b0;
			ff1_q <= 1'b0;
		end else if (ctl.mode == MODE_INTERVAL || ctl.mode == MODE_FREE_RUN) begin
			ff0_q <= ff0_q ^ m0;
			ff1_q <= ff1_q ^ m1;
		end else begin
			ff0_q <= ff0_q ^ m0;
			if (m0 || (trig_go && st_q == ST_RUN)) begin
				ff1_q <= 1'b0;
			end else if (m1) begin
				ff1_q <= 1'b1;
			end
		end
	end

	// Level bit sets the idle level and inverts the active phase
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			timer_out_pin_0 <= 1'b0;
			timer_out_pin_1 <= 1'b0;
		end else begin
			timer_out_pin_0 <= ctl.output_level_0 ^ (ctl.output_enable_0 & ff0_q);
			timer_out_pin_1 <= ctl.output_level_1 ^ (ctl.output_enable_1 & ff1_q);
		end
	end

	a_pin_follows_level: assert property (@(posedge clk) disable iff (!arst_n)
		!ctl.output_enable_0 |=> timer_out_pin_0 == $past(ctl.output_level_0))
		else $error("pin 0 does not follow its level bit");

	a_no_capture_interval: assert property (@(posedge clk) disable iff (!arst_n)
		(ctl.mode == MODE_INTERVAL && !cmp_wr.wr1) |=> $stable(compare_reg_1))
		else $error("compare 1 changed without write outside capture modes");

	a_event_edge_off: assert property (@(posedge clk) disable iff (!arst_n)
		(ctl.count_run_enable && ext_clk && ctl.event_edge_select == EDGE_NONE
		&& ctl.mode != MODE_PULSE_WIDTH && !trig_go) |=> $stable(counter_value_reg))
		else $error("counter moved with no event edge selected");

	a_trigger_gate: assert property (@(posedge clk) disable iff (!arst_n)
		(ctl.count_run_enable && trig_mode && st_q == ST_IDLE && !ctl.software_trigger
		&& ctl.trigger_edge_select == EDGE_NONE) |=> st_q == ST_IDLE)
		else $error("trigger mode started with trigger edge disabled");

	a_event_no_capture: assert property (@(posedge clk) disable iff (!arst_n)
		(ctl.mode == MODE_EXT_EVENT && !cmp_wr.wr0) |=> $stable(compare_reg_0))
		else $error("capture on pin 0 in event count mode");

	a_event_no_output: assert property (@(posedge clk) disable iff (!arst_n)
		(ctl.mode == MODE_EXT_EVENT) [*2] |=> timer_out_pin_1 == $past(ctl.output_level_1))
		else $error("timer output active in event count mode");

	a_sw_trig_ignored: assert property (@(posedge clk) disable iff (!arst_n)
		(run && (ctl.mode == MODE_INTERVAL || ctl.mode == MODE_EXT_EVENT)
		&& ctl.software_trigger && !tick)
		|=> $stable(counter_value_reg))
		else $error("software trigger acted outside trigger modes");

	a_one_shot_blocked: assert property (@(posedge clk) disable iff (!arst_n)
		(ctl.mode == MODE_ONE_SHOT && compare_reg_1 > compare_reg_0) [*2]
		|=> timer_out_pin_1 == $past(ctl.output_level_1))
		else $error("one-shot pulse with compare 1 above compare 0");
endmodule
`default_nettype wire

// file: rtl/tmr_pkg.sv
package tmr_pkg;
	localparam logic [2:0] MODE_INTERVAL = 3'h0;
	localparam logic [2:0] MODE_EXT_EVENT = 3'h1;
	localparam logic [2:0] MODE_EXT_TRIG = 3'h2;
	localparam logic [2:0] MODE_ONE_SHOT = 3'h3;
	localparam logic [2:0] MODE_PWM = 3'h4;
	localparam logic [2:0] MODE_FREE_RUN = 3'h5;
	localparam logic [2:0] MODE_PULSE_WIDTH = 3'h6;
	localparam logic [1:0] EDGE_NONE = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;
	localparam int CNT_W = 16;
	localparam int DIV_W = 8;
	localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
	localparam logic [CNT_W-1:0] CMP_RST = 16'h0000;
	localparam logic [DIV_W-1:0] DIV_RST = 8'h00;
	localparam int CAP0_LSB = 0;
	localparam int CAP1_LSB = 2;

	typedef struct packed {
		logic count_run_enable;
		logic [2:0] mode;
		logic external_event_clock_select;
		logic [2:0] prescale;
		logic software_trigger;
		logic output_level_0;
		logic output_level_1;
		logic output_enable_0;
		logic output_enable_1;
		logic [3:0] capture_edge_select;
		logic [1:0] event_edge_select;
		logic [1:0] trigger_edge_select;
		logic capture_compare_select_0;
		logic capture_compare_select_1;
	} ctl_t;

	typedef struct packed {
		logic wr0;
		logic wr1;
		logic [CNT_W-1:0] data;
	} cmp_wr_t;
endpackage

// file: testbench/edge_source.sv
`timescale 1ns/1ps
`default_nettype none
module edge_source (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [2:0] kick,
	output logic [2:0] pins
);
	// Levels move only on the edge, as a synchronised outside source would
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pins <= 3'h0;
		end else begin
			pins <= pins ^ kick;
		end
	end
endmodule
`default_nettype wire

// file: testbench/timer_event_counter_p_test.sv
`timescale 1ns/1ps
`default_nettype none
module timer_event_counter_p_test;
	import tmr_pkg::*;
	logic clk;
	logic arst_n;
	ctl_t c;
	cmp_wr_t w;
	logic [2:0] kick;
	logic [2:0] pins;
	logic o0;
	logic o1;
	logic [15:0] cnt;
	logic [15:0] r0;
	logic [15:0] r1;
	logic i0;
	logic i1;
	int n_mismatch = 0;
	int check_count = 0;
	int cyc = 0;

	edge_source src (.clk(clk), .arst_n(arst_n), .kick(kick), .pins(pins));
	timer_event_counter_p dut (.clk(clk), .arst_n(arst_n), .ctl(c), .cmp_wr(w),
		.capture_trigger_pin_0(pins[0]), .capture_trigger_pin_1(pins[1]),
		.ext_trigger_pin(pins[2]), .timer_out_pin_0(o0), .timer_out_pin_1(o1),
		.counter_value_reg(cnt), .compare_reg_0(r0), .compare_reg_1(r1),
		.compare0_match_interrupt(i0), .compare1_match_interrupt(i1));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic check(input string nm, input logic [15:0] s, input logic [15:0] e);
		check_count++;
		if (s !== e) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic complete_run;
		$display("mismatches %0d checks %0d", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// One toggle of a far-side pin; two make a full pulse
	task automatic tog(input int i);
		kick[i] = 1'b1;
		step(1);
		kick[i] = 1'b0;
		step(2);
	endtask
	task automatic pulses(input int i, input int n);
		repeat (2 * n) tog(i);
		step(3);
	endtask
	task automatic wr(input logic sel, input logic [15:0] v);
		w.data = v;
		w.wr0 = !sel;
		w.wr1 = sel;
		step(1);
		w.wr0 = 1'b0;
		w.wr1 = 1'b0;
		step(1);
	endtask
	// Config is only touched between halt and go; only software_trigger is pulsed while counting
	task automatic halt;
		c.count_run_enable = 1'b0;
		step(2);
	endtask
	task automatic go(input logic [2:0] m);
		c.mode = m;
		step(1);
		c.count_run_enable = 1'b1;
		step(1);
	endtask
	task automatic trig;
		c.software_trigger = 1'b1;
		step(1);
		c.software_trigger = 1'b0;
	endtask
	task automatic watch(input logic e);
		logic seen;
		logic seen_m0;
		logic seen_m1;
		seen = 1'b0;
		seen_m0 = 1'b0;
		seen_m1 = 1'b0;
		repeat (12) begin
			step(1);
			seen = seen | o1;
			seen_m0 = seen_m0 | i0;
			seen_m1 = seen_m1 | i1;
		end
		check("pulse1", seen, e);
		check("irq0", seen_m0, 1'b1);
		check("irq1", seen_m1, e);
	endtask

	task automatic t_level;
		halt();
		c.output_level_0 = 1'b1;
		step(2);
		check("out0", o0, 1'b1);
		c.output_level_1 = 1'b1;
		c.output_level_0 = 1'b0;
		step(2);
		check("out0", o0, 1'b0);
		check("out1", o1, 1'b1);
		c.output_level_1 = 1'b0;
	endtask
	task automatic t_events;
		halt();
		wr(0, 16'hFFFF);
		c.event_edge_select = EDGE_RISE;
		go(MODE_EXT_EVENT);
		pulses(0, 3);
		check("cnt_rise", cnt, 16'h0003);
		halt();
		c.event_edge_select = EDGE_BOTH;
		go(MODE_EXT_EVENT);
		pulses(0, 3);
		check("cnt_both", cnt, 16'h0006);
		halt();
		c.event_edge_select = EDGE_NONE;
		go(MODE_EXT_EVENT);
		pulses(0, 1);
		check("cnt_none", cnt, 16'h0000);
		halt();
		wr(0, 16'h0001);
		c.event_edge_select = EDGE_RISE;
		c.output_enable_0 = 1'b1;
		go(MODE_EXT_EVENT);
		pulses(0, 2);
		check("out0_evt", o0, 1'b0);
		halt();
		c.external_event_clock_select = 1'b1;
		go(MODE_INTERVAL);
		pulses(0, 2);
		check("out0_int", o0, 1'b1);
		halt();
		c.external_event_clock_select = 1'b0;
	endtask
	task automatic t_trigger;
		halt();
		c.output_enable_0 = 1'b0;
		c.output_level_0 = 1'b0;
		wr(0, 16'h0100);
		c.trigger_edge_select = EDGE_RISE;
		go(MODE_EXT_EVENT);
		pulses(0, 2);
		trig();
		pulses(2, 1);
		check("cnt_evt", cnt, 16'h0002);
		halt();
		go(MODE_ONE_SHOT);
		step(4);
		check("cnt_idle", cnt, 16'h0000);
		pulses(2, 1);
		check("cnt_ext", cnt !== 16'h0000, 1'b1);
		halt();
		c.trigger_edge_select = EDGE_NONE;
		go(MODE_ONE_SHOT);
		pulses(2, 1);
		check("cnt_gate", cnt, 16'h0000);
		halt();
		go(MODE_ONE_SHOT);
		trig();
		step(3);
		check("cnt_sw", cnt !== 16'h0000, 1'b1);
	endtask
	task automatic t_capture;
		halt();
		wr(0, 16'h1234);
		c.capture_compare_select_0 = 1'b1;
		c.capture_edge_select = {2'h0, EDGE_RISE};
		go(MODE_INTERVAL);
		pulses(0, 1);
		check("cap_off", r0, 16'h1234);
		halt();
		go(MODE_FREE_RUN);
		pulses(0, 1);
		check("cap_on", r0 !== 16'h1234, 1'b1);
	endtask
	task automatic t_oneshot;
		halt();
		wr(0, 16'h0004);
		wr(1, 16'h0008);
		check("cmp1", r1, 16'h0008);
		c.output_enable_1 = 1'b1;
		go(MODE_ONE_SHOT);
		trig();
		watch(1'b0);
		halt();
		wr(1, 16'h0002);
		go(MODE_ONE_SHOT);
		trig();
		watch(1'b1);
	endtask

	initial begin
		arst_n = 1'b0;
		c = '0;
		w = '0;
		kick = 3'h0;
		step(8);
		arst_n = 1'b1;
		step(1);
		t_level();
		t_events();
		t_trigger();
		t_capture();
		t_oneshot();
		complete_run();
	end
	// Whole run needs well under a thousand cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_mismatch++;
			complete_run();
		end
	end
endmodule
`default_nettype wire
